// *** hdl/can_trx_supply_ctrl.sv ***
// Notes on behaviour
// - Raise system reset while rail is below the selected threshold.
// - Threshold select: 00=90 %, 01=80 %, 10=70 %, 11=60 %.
// - Threshold select loads its start-up default after power-up.
// - Rail falling below 90 % with warning enabled captures event.
// - Supply-low flag follows the 90 % comparator, zero after reset.
// - Normal chip mode: 01/10 Active, 11 Listen-only, 00 Offline.
// - Standby forces Offline or Offline Bias whatever the mode field.
// - Mode 01: rail below 90 % moves Active to Offline/Bias.
// - Mode 10: stay active until reset threshold; then Offline/Bias.
// - Active requested with transmit low: Listen-only until it rises.
// - Mode 01 with rail below 90 % keeps Listen-only.
// - Listen-only never drives the bus; receiver and bias stay on.
// - Active passes bus level to receive output, drives transmit.
// - Mid bias in Active, Listen-only, Offline Bias; ground in Offline.
// - Offline goes to Offline Bias on activity, back after silence.
// - Wake watching in Offline only while bus wake enable is set.
// - Leaving bus modes goes Offline if quiet, else via Offline Bias.
// - Software can read whether the transceiver is Active.
// - Active status sits at bit 7 of transceiver status.
// - Chip leaving Off into Reset puts transceiver in Offline.
`timescale 1ns/10ps
module can_trx_supply_ctrl #(
  parameter int unsigned SILENCE_CYCLES = trx_supply_pkg::SILENCE_CYCLES
) (
  // Clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [trx_supply_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Chip mode controller and configuration storage
  input  wire logic [1:0]                         chip_mode_sel,
  input  wire logic [1:0]                         startup_threshold_default,
  // Rail comparators, bit 0..3 = below 90/80/70/60 %
  input  wire logic [3:0]                         mcu_supply_rail_below,
  // Protocol controller side
  input  wire logic                               txd,
  output logic                                    rxd,
  // Analog bus front end
  input  wire logic                               bus_rx_level,
  output logic                                    bus_tx_dominant,
  output logic                                    bias_mid_en,
  output logic                                    bias_gnd_en,
  output logic                                    wake_watch_en,
  // System
  output logic                                    system_reset_req,
  output logic                                    trx_active
);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  localparam int unsigned N_SYNC = 6;
  // Idle pin levels: rail fine, bus and transmit recessive
  localparam logic [N_SYNC-1:0] SYNC_IDLE = 6'h30;

  wire [N_SYNC-1:0] raw_in = {bus_rx_level, txd, mcu_supply_rail_below};
  wire [N_SYNC-1:0] filt_in;

  genvar gi;
  generate
    for (gi = 0; gi < N_SYNC; gi++) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic filt_reg;
      // Start at the idle level, else release fakes a bus edge
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg   <= SYNC_IDLE[gi];
          s2_reg   <= SYNC_IDLE[gi];
          s3_reg   <= SYNC_IDLE[gi];
          filt_reg <= SYNC_IDLE[gi];
        end else begin
          s1_reg <= raw_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // Accept a change only once two stages agree
          if (s2_reg == s3_reg) begin
            filt_reg <= s3_reg;
          end
        end
      end
      assign filt_in[gi] = filt_reg;
    end
  endgenerate

  wire [3:0] rail_below = filt_in[3:0];
  wire       txd_s      = filt_in[4];
  wire       bus_rx_s   = filt_in[5];

  // ********************************************************
  // Registers
  // ********************************************************
  logic [1:0] reset_threshold_sel_reg;
  logic       startup_load_reg;
  logic [1:0] transceiver_mode_sel_reg;
  logic       bus_wake_enable_reg;
  logic       supply_low_warning_enable_reg;
  logic       supply_low_warning_event_reg;
  logic       supply_low_warning_event_next;
  logic       low90_prev_reg;
  logic       bus_rx_prev_reg;

  // ********************************************************
  // APB decode
  // ********************************************************
  wire setup_ph  = psel && !penable;
  wire access_ph = psel && penable && pready;
  wire wr_en     = access_ph && pwrite;

  wire hit_thr  = paddr == trx_supply_pkg::ADDR_THRESHOLD_CTRL;
  wire hit_sup  = paddr == trx_supply_pkg::ADDR_SUPPLY_STATUS;
  wire hit_tctl = paddr == trx_supply_pkg::ADDR_TRX_CTRL;
  wire hit_tsts = paddr == trx_supply_pkg::ADDR_TRX_STATUS;
  wire hit_ev   = paddr == trx_supply_pkg::ADDR_EVENTS;
  wire mapped   = hit_thr || hit_sup || hit_tctl || hit_tsts || hit_ev;

  wire wr_thr  = wr_en && hit_thr;
  wire wr_tctl = wr_en && hit_tctl;
  wire wr_ev   = wr_en && hit_ev;

  // ********************************************************
  // Supply supervision
  // ********************************************************
  wire low90     = rail_below[trx_supply_pkg::RAIL_90];
  // Threshold code indexes the comparator vector directly
  wire below_thr = rail_below[reset_threshold_sel_reg];
  wire warn_set  = low90 && !low90_prev_reg &&
                   supply_low_warning_enable_reg;
  wire warn_clr  = wr_ev && pwdata[trx_supply_pkg::EV_WARN_BIT];

  // Set wins over a clear landing in the same cycle
  assign supply_low_warning_event_next =
    warn_set || (supply_low_warning_event_reg && !warn_clr);

  // ********************************************************
  // Transceiver mode machine
  // ********************************************************
  trx_ctrl_if tc ();

  assign tc.chip_mode            = trx_supply_pkg::chip_mode_t'(chip_mode_sel);
  assign tc.transceiver_mode_sel = transceiver_mode_sel_reg;
  assign tc.low90                = low90;
  assign tc.below_thr            = below_thr;
  assign tc.txd_low              = !txd_s;
  assign tc.bus_edge             = bus_rx_s != bus_rx_prev_reg;

  trx_mode_fsm #(
    .SILENCE_CYCLES (SILENCE_CYCLES)
  ) u_fsm (
    .pclk    (pclk),
    .presetn (presetn),
    .c       (tc)
  );

  wire st_active  = tc.state == trx_supply_pkg::TRX_ACTIVE;
  wire st_listen  = tc.state == trx_supply_pkg::TRX_LISTEN;
  wire st_offline = tc.state == trx_supply_pkg::TRX_OFFLINE;
  wire bus_facing = st_active || st_listen;

  // ********************************************************
  // Read mux
  // ********************************************************
  wire [7:0] thr_rd  = {6'h0, reset_threshold_sel_reg};
  wire [7:0] sup_rd  = {7'h0, low90};
  wire [7:0] tctl_rd = {4'h0, supply_low_warning_enable_reg,
                        bus_wake_enable_reg, transceiver_mode_sel_reg};
  wire [7:0] tsts_rd = {st_active, 3'h0, tc.silent, 1'h0,
                        low90 && (transceiver_mode_sel_reg ==
                                  trx_supply_pkg::MODE_ACTIVE_UV),
                        1'h0};
  wire [7:0] ev_rd   = {7'h0, supply_low_warning_event_reg};
  wire [7:0] rd_mux  = hit_thr  ? thr_rd  :
                       hit_sup  ? sup_rd  :
                       hit_tctl ? tctl_rd :
                       hit_tsts ? tsts_rd :
                       hit_ev   ? ev_rd   : 8'h0;

  // ********************************************************
  // APB response, one access cycle, no extra waits
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph && !mapped;
      if (setup_ph) begin
        prdata <= pwrite ? 32'h0 : {24'h0, rd_mux};
      end
    end
  end

  // ********************************************************
  // Register writes
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_threshold_sel_reg <= trx_supply_pkg::THR_RST;
      startup_load_reg        <= 1'b1;
    end else begin
      startup_load_reg <= 1'b0;
      // Default strap caught on the first edge after release
      if (startup_load_reg) begin
        reset_threshold_sel_reg <= startup_threshold_default;
      end else if (wr_thr) begin
        reset_threshold_sel_reg <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transceiver_mode_sel_reg      <= trx_supply_pkg::MODE_RST;
      bus_wake_enable_reg           <= trx_supply_pkg::WAKE_EN_RST;
      supply_low_warning_enable_reg <= trx_supply_pkg::WARN_EN_RST;
    end else if (wr_tctl) begin
      transceiver_mode_sel_reg      <= pwdata[1:0];
      bus_wake_enable_reg           <= pwdata[trx_supply_pkg::TC_WAKE_EN_BIT];
      supply_low_warning_enable_reg <= pwdata[trx_supply_pkg::TC_WARN_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_low_warning_event_reg <= 1'b0;
      low90_prev_reg               <= 1'b0;
      bus_rx_prev_reg              <= 1'b1;
    end else begin
      supply_low_warning_event_reg <= supply_low_warning_event_next;
      low90_prev_reg               <= low90;
      bus_rx_prev_reg              <= bus_rx_s;
    end
  end

  // ********************************************************
  // Registered outputs
  // ********************************************************
  // Receiver idles recessive outside bus-facing modes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd              <= 1'b1;
      bus_tx_dominant  <= 1'b0;
      bias_mid_en      <= 1'b0;
      bias_gnd_en      <= 1'b1;
      wake_watch_en    <= 1'b0;
      system_reset_req <= 1'b0;
      trx_active       <= 1'b0;
    end else begin
      rxd              <= bus_facing ? bus_rx_s : 1'b1;
      bus_tx_dominant  <= st_active && !txd_s;
      bias_mid_en      <= !st_offline;
      bias_gnd_en      <= st_offline;
      wake_watch_en    <= st_offline && bus_wake_enable_reg;
      system_reset_req <= below_thr;
      trx_active       <= st_active;
    end
  end

endmodule

// *** hdl/trx_ctrl_if.sv ***
`timescale 1ns/10ps
interface trx_ctrl_if;
  trx_supply_pkg::chip_mode_t chip_mode;
  logic [1:0]                 transceiver_mode_sel;
  logic                       low90;
  logic                       below_thr;
  logic                       txd_low;
  logic                       bus_edge;
  trx_supply_pkg::trx_state_t state;
  logic                       silent;

  modport ctrl (
    output chip_mode, transceiver_mode_sel, low90, below_thr, txd_low,
    output bus_edge,
    input  state, silent
  );
  modport fsm (
    input  chip_mode, transceiver_mode_sel, low90, below_thr, txd_low,
    input  bus_edge,
    output state, silent
  );
endinterface

// *** hdl/trx_mode_fsm.sv ***
`timescale 1ns/10ps
module trx_mode_fsm #(
  parameter int unsigned SILENCE_CYCLES = trx_supply_pkg::SILENCE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  trx_ctrl_if.fsm  c
);
  localparam int unsigned CW = $clog2(SILENCE_CYCLES + 1);
  localparam logic [CW-1:0] SIL_MAX = CW'(SILENCE_CYCLES);

  trx_supply_pkg::trx_state_t state_reg;
  trx_supply_pkg::trx_state_t state_next;
  trx_supply_pkg::chip_mode_t chip_prev_reg;
  logic [CW-1:0]              sil_cnt_reg;

  wire normal    = c.chip_mode == trx_supply_pkg::CHIP_NORMAL;
  wire sel_uv    = c.transceiver_mode_sel == trx_supply_pkg::MODE_ACTIVE_UV;
  wire sel_nuv   = c.transceiver_mode_sel == trx_supply_pkg::MODE_ACTIVE_NUV;
  wire sel_lo    = c.transceiver_mode_sel == trx_supply_pkg::MODE_LISTEN;
  wire want_act  = normal && (sel_uv || sel_nuv);
  wire uv_block  = sel_uv && c.low90;
  wire thr_block = sel_nuv && c.below_thr;
  wire from_off  = chip_prev_reg == trx_supply_pkg::CHIP_OFF &&
                   c.chip_mode == trx_supply_pkg::CHIP_RESET;
  wire silent    = sil_cnt_reg >= SIL_MAX;
  // Leaving a bus-facing mode: straight to Offline only on a quiet bus
  wire trx_supply_pkg::trx_state_t quit_to =
    silent ? trx_supply_pkg::TRX_OFFLINE
           : trx_supply_pkg::TRX_OFF_BIAS;

  always_comb begin
    state_next = state_reg;
    if (from_off) begin
      state_next = trx_supply_pkg::TRX_OFFLINE;
    end else begin
      unique case (state_reg)
        trx_supply_pkg::TRX_ACTIVE: begin
          // Standby, Reset and mode 00 all drop want_act
          if (!want_act || uv_block || thr_block) begin
            state_next = quit_to;
          end
        end
        trx_supply_pkg::TRX_LISTEN: begin
          if (normal && sel_lo) begin
            state_next = trx_supply_pkg::TRX_LISTEN;
          end else if (!want_act || thr_block) begin
            state_next = quit_to;
          end else if (!c.txd_low && !uv_block) begin
            state_next = trx_supply_pkg::TRX_ACTIVE;
          end
        end
        trx_supply_pkg::TRX_OFFLINE, trx_supply_pkg::TRX_OFF_BIAS: begin
          if (want_act && !uv_block && !thr_block) begin
            state_next = c.txd_low ? trx_supply_pkg::TRX_LISTEN
                                   : trx_supply_pkg::TRX_ACTIVE;
          end else if (normal && sel_lo) begin
            state_next = trx_supply_pkg::TRX_LISTEN;
          end else if (state_reg == trx_supply_pkg::TRX_OFFLINE) begin
            if (c.bus_edge || (want_act && uv_block)) begin
              state_next = trx_supply_pkg::TRX_OFF_BIAS;
            end
          end else if (silent) begin
            state_next = trx_supply_pkg::TRX_OFFLINE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= trx_supply_pkg::TRX_OFFLINE;
      chip_prev_reg <= trx_supply_pkg::CHIP_OFF;
      sil_cnt_reg   <= SIL_MAX;
    end else begin
      state_reg     <= state_next;
      chip_prev_reg <= c.chip_mode;
      // Restart on every edge, saturate once the bus is quiet
      if (c.bus_edge) begin
        sil_cnt_reg <= '0;
      end else if (!silent) begin
        sil_cnt_reg <= sil_cnt_reg + CW'(1);
      end
    end
  end

  assign c.state  = state_reg;
  assign c.silent = silent;
endmodule

// *** hdl/trx_supply_pkg.sv ***
package trx_supply_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned SILENCE_TIME_US = 1000;
  localparam int unsigned SILENCE_CYCLES  =
    SILENCE_TIME_US * (CLK_HZ / 1_000_000);

  // ********************************************************
  // Register indices; byte address is four times the index
  // ********************************************************
  localparam int unsigned ADDR_W             = 8;
  localparam int unsigned IDX_THRESHOLD_CTRL = 'h10;
  localparam int unsigned IDX_SUPPLY_STATUS  = 'h1b;
  localparam int unsigned IDX_TRX_CTRL       = 'h20;
  localparam int unsigned IDX_TRX_STATUS     = 'h22;
  localparam int unsigned IDX_EVENTS         = 'h30;
  localparam logic [7:0] ADDR_THRESHOLD_CTRL = 8'(IDX_THRESHOLD_CTRL * 4);
  localparam logic [7:0] ADDR_SUPPLY_STATUS  = 8'(IDX_SUPPLY_STATUS * 4);
  localparam logic [7:0] ADDR_TRX_CTRL       = 8'(IDX_TRX_CTRL * 4);
  localparam logic [7:0] ADDR_TRX_STATUS     = 8'(IDX_TRX_STATUS * 4);
  localparam logic [7:0] ADDR_EVENTS         = 8'(IDX_EVENTS * 4);

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int unsigned TC_WAKE_EN_BIT    = 2;
  localparam int unsigned TC_WARN_EN_BIT    = 3;
  localparam int unsigned TS_ACTIVE_BIT     = 7;
  localparam int unsigned TS_SILENT_BIT     = 3;
  localparam int unsigned TS_SUPPLY_LOW_BIT = 1;
  localparam int unsigned SS_LOW_BIT        = 0;
  localparam int unsigned EV_WARN_BIT       = 0;
  localparam int unsigned RAIL_90           = 0;

  // ********************************************************
  // Values after reset and codes
  // ********************************************************
  localparam logic [1:0] THR_RST         = 2'h0;
  localparam logic [1:0] MODE_RST        = 2'h0;
  localparam logic       WAKE_EN_RST     = 1'h0;
  localparam logic       WARN_EN_RST     = 1'h0;
  localparam logic [1:0] MODE_OFFLINE    = 2'h0;
  localparam logic [1:0] MODE_ACTIVE_UV  = 2'h1;
  localparam logic [1:0] MODE_ACTIVE_NUV = 2'h2;
  localparam logic [1:0] MODE_LISTEN     = 2'h3;

  typedef enum logic [1:0] {
    CHIP_OFF     = 2'h0,
    CHIP_RESET   = 2'h1,
    CHIP_STANDBY = 2'h2,
    CHIP_NORMAL  = 2'h3
  } chip_mode_t;

  typedef enum logic [3:0] {
    TRX_ACTIVE   = 4'h1,
    TRX_LISTEN   = 4'h2,
    TRX_OFFLINE  = 4'h4,
    TRX_OFF_BIAS = 4'h8
  } trx_state_t;

endpackage

// *** verif/can_ctrl_model.sv ***
`timescale 1ns/10ps
module can_ctrl_model (
  // Clock
  input  wire logic pclk,
  // Bench command
  input  wire logic hold_low,
  // Pins
  output logic      txd
);
  // ****
  // Transmit
  // ****
  // Recessive unless told to send; registered on pclk
  always @(posedge pclk) txd <= !hold_low;
endmodule

// *** verif/can_trx_supply_ctrl_monitor.sv ***
`timescale 1ns/10ps
module can_trx_supply_ctrl_monitor #(
  parameter int unsigned SILENCE_CYCLES = trx_supply_pkg::SILENCE_CYCLES
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Mode and rail
  input wire logic [1:0] chip_mode_sel,
  input wire logic [3:0] mcu_supply_rail_below,
  // Bus and system
  input wire logic       bus_rx_level,
  input wire logic       bus_tx_dominant,
  input wire logic       bias_mid_en,
  input wire logic       bias_gnd_en,
  input wire logic       wake_watch_en,
  input wire logic       system_reset_req,
  input wire logic       trx_active
);
  // ****
  // Quiet time in standby
  // ****
  int unsigned quiet_cnt;
  logic        bus_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_cnt <= 0;
      bus_d     <= 1'b1;
    end else begin
      bus_d <= bus_rx_level;
      if (bus_rx_level != bus_d || chip_mode_sel != 2'h2) begin
        quiet_cnt <= 0;
      end else if (quiet_cnt < SILENCE_CYCLES + 16) begin
        quiet_cnt <= quiet_cnt + 1;
      end
    end
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_reset_clear: assert property (
    (mcu_supply_rail_below == 4'h0) [*6] |-> !system_reset_req)
    else $error("reset with rail good");
  a_reset_lowest: assert property (
    (mcu_supply_rail_below == 4'hf) [*6] |-> system_reset_req)
    else $error("no reset below lowest threshold");
  a_idle_no_drive: assert property (
    !trx_active |-> !bus_tx_dominant)
    else $error("bus driven outside active");
  a_bias_split: assert property (bias_mid_en != bias_gnd_en)
    else $error("bias enables not exclusive");
  a_active_bias: assert property (trx_active |-> bias_mid_en)
    else $error("active without mid bias");
  a_wake_offline: assert property (wake_watch_en |-> bias_gnd_en)
    else $error("wake watch outside offline");
  a_standby_off: assert property (
    (chip_mode_sel == 2'h2) [*7] |-> !trx_active)
    else $error("active in standby");
  a_edge_bias: assert property (
    bias_gnd_en && chip_mode_sel == 2'h2 && bus_rx_level != bus_d
    |-> ##[2:10] bias_mid_en)
    else $error("bus activity left offline");
  a_silence_back: assert property (
    quiet_cnt >= SILENCE_CYCLES + 12 |-> bias_gnd_en)
    else $error("no return to offline after silence");
endmodule
bind can_trx_supply_ctrl can_trx_supply_ctrl_monitor #(
  .SILENCE_CYCLES(SILENCE_CYCLES)
) u_mon (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pready                (pready),
  .chip_mode_sel         (chip_mode_sel),
  .mcu_supply_rail_below (mcu_supply_rail_below),
  .bus_rx_level          (bus_rx_level),
  .bus_tx_dominant       (bus_tx_dominant),
  .bias_mid_en           (bias_mid_en),
  .bias_gnd_en           (bias_gnd_en),
  .wake_watch_en         (wake_watch_en),
  .system_reset_req      (system_reset_req),
  .trx_active            (trx_active)
);

// *** verif/test_can_trx_supply_ctrl.sv ***
`timescale 1ns/10ps
module test_can_trx_supply_ctrl;
  // ****
  // Signals
  // ****
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, txd, rxd, hold_low, bus_drv;
  logic [1:0]  chip_mode_sel, startup_threshold_default;
  logic [3:0]  rail;
  wire         bus_rx_level;
  logic        bus_tx_dominant, bias_mid_en, bias_gnd_en;
  logic        wake_watch_en, system_reset_req, trx_active;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          bad_count, cmp_count, tick, t, k, seed;
  always #50 pclk = ~pclk;
  // Wired bus: a dominant driver wins
  assign bus_rx_level = bus_drv & !bus_tx_dominant;
  can_trx_supply_ctrl #(.SILENCE_CYCLES(20)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_mode_sel(chip_mode_sel),
    .startup_threshold_default(startup_threshold_default),
    .mcu_supply_rail_below(rail), .txd(txd), .rxd(rxd),
    .bus_rx_level(bus_rx_level), .bus_tx_dominant(bus_tx_dominant),
    .bias_mid_en(bias_mid_en), .bias_gnd_en(bias_gnd_en),
    .wake_watch_en(wake_watch_en), .system_reset_req(system_reset_req),
    .trx_active(trx_active));
  can_ctrl_model u_ctrl (.pclk(pclk), .hold_low(hold_low), .txd(txd));
  // ****
  // Tasks
  // ****
  task chk(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: reg %h want %h", $time, got, want);
    end
  endtask
  task chk_pin(input logic got, input logic want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: pin %b want %b", $time, got, want);
    end
  endtask
  task results;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d,
           input logic [32:0] x);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'($random(seed)), d};
    exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    // Wait until pready reads 1; the bench timeout ends a wait that hangs
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h0, {25'h0, d});
  endtask
  function automatic logic [3:0] lvl(input int n);
    return 4'((5'h1 << n) - 5'h1);
  endfunction
  // ****
  // Result watcher and timeout
  // ****
  always @(posedge pclk) begin
    tick++;
    if (tick > 6000) begin
      bad_count++;
      results();
    end
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      if (!pwrite) chk(prdata, e[31:0]);
      chk_pin(pslverr, e[32]);
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    seed = 78;
    {psel, penable, pwrite, paddr, pwdata, hold_low} = '0;
    {presetn, rail, bus_drv, chip_mode_sel} = {1'b0, 4'h0, 1'b1, 2'h3};
    startup_threshold_default = 2'h2;
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
    rd(trx_supply_pkg::ADDR_THRESHOLD_CTRL, 8'h2);
    rd(trx_supply_pkg::ADDR_TRX_STATUS, 8'h08);
    apb(1'b0, 8'h04, 8'h0, {1'b1, 32'h0});
    for (t = 0; t < 4; t++) begin
      wr(trx_supply_pkg::ADDR_THRESHOLD_CTRL, 8'(t));
      rd(trx_supply_pkg::ADDR_THRESHOLD_CTRL, 8'(t));
      for (k = 0; k < 5; k++) begin
        rail <= lvl(k);
        cyc(8);
        chk_pin(system_reset_req, k > t);
        rd(trx_supply_pkg::ADDR_SUPPLY_STATUS, 8'(k > 0));
      end
    end
    rail <= 4'h0;
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h8);
    rail <= 4'h1;
    cyc(8);
    rd(trx_supply_pkg::ADDR_EVENTS, 8'h1);
    wr(trx_supply_pkg::ADDR_EVENTS, 8'h1);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h0);
    rail <= 4'h0;
    cyc(8);
    rail <= 4'h1;
    cyc(8);
    rd(trx_supply_pkg::ADDR_EVENTS, 8'h0);
    rail <= 4'h0;
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h1);
    cyc(8);
    chk_pin(trx_active, 1'b1);
    rd(trx_supply_pkg::ADDR_TRX_STATUS, 8'h88);
    hold_low <= 1'b1;
    cyc(14);
    chk_pin(bus_tx_dominant, 1'b1);
    chk_pin(rxd, 1'b0);
    hold_low <= 1'b0;
    rail <= 4'h1;
    cyc(8);
    chk_pin(trx_active, 1'b0);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h3);
    cyc(8);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h1);
    cyc(8);
    chk_pin(trx_active, 1'b0);
    chk_pin(bias_mid_en, 1'b1);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h2);
    cyc(8);
    chk_pin(trx_active, 1'b1);
    rail <= 4'hf;
    cyc(8);
    chk_pin(trx_active, 1'b0);
    rail <= 4'h0;
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h3);
    bus_drv  <= 1'b0;
    hold_low <= 1'b1;
    cyc(14);
    chk_pin(rxd, 1'b0);
    chk_pin(bus_tx_dominant, 1'b0);
    bus_drv <= 1'b1;
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h1);
    cyc(8);
    chk_pin(trx_active, 1'b0);
    hold_low <= 1'b0;
    cyc(10);
    chk_pin(trx_active, 1'b1);
    cyc(30);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h4);
    cyc(8);
    chk_pin(bias_gnd_en, 1'b1);
    chk_pin(wake_watch_en, 1'b1);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h2);
    repeat (3) begin
      bus_drv <= 1'b0;
      cyc(8);
      bus_drv <= 1'b1;
      cyc(6 + ($random(seed) & 7));
    end
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h0);
    cyc(6);
    chk_pin(bias_mid_en, 1'b1);
    cyc(40);
    chk_pin(bias_gnd_en, 1'b1);
    chk_pin(wake_watch_en, 1'b0);
    wr(trx_supply_pkg::ADDR_TRX_CTRL, 8'h1);
    cyc(8);
    chip_mode_sel <= 2'h2;
    cyc(40);
    chk_pin(trx_active, 1'b0);
    bus_drv <= 1'b0;
    cyc(10);
    chk_pin(bias_mid_en, 1'b1);
    bus_drv <= 1'b1;
    // Let the last edge reach the machine before leaving Off
    cyc(8);
    chip_mode_sel <= 2'h0;
    cyc(3);
    chip_mode_sel <= 2'h1;
    cyc(8);
    chk_pin(bias_gnd_en, 1'b1);
    startup_threshold_default <= 2'h1;
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(2);
    rd(trx_supply_pkg::ADDR_THRESHOLD_CTRL, 8'h1);
    results();
  end
endmodule
